//--- rtl/sec_eeprom.sv
// Contract
// - Chip select high: deselected, output floats
// - Deselect gives standby; internal write continues
// - Sample input on serial clock rise
// - Change output on serial clock fall
// - Pause floats output, ignores clock, input
// - Six check bits per group; correct one
// - Any write rewrites whole four-byte group
// - Unknown opcode: ignore rest of frame
// - Read 03, write 02, 16-bit address
// - Read keeps streaming following bytes
// - Status write 01 then one byte
// - Lock bit plus guard low: hardware lock
// - Protect pair nonvolatile, selects protected area
// - Latch set by enable only; gates writes
// - Latch cleared reset, disable, write done
// - Busy bit reads one during write
// - Enable 06 only with exactly 8 clocks
// - Disable 04 only with exactly 8 clocks
// - Status read repeats, live latch, busy
// - Status bits 6..4 read zero
// - Protect map 00 none,01 C000,10 8000,11 all
// - Read address increments and wraps
`default_nettype none
module sec_eeprom #(
  parameter int ADDR_W = 16,
  parameter int WRITE_TIME = sec_pkg::WRITE_CYCLES
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RESET,
  // Serial link
  input wire logic CS_N,
  input wire logic SCK,
  input wire logic SI,
  input wire logic HOLD_N,
  input wire logic WP_N,
  output logic SO,
  output logic SO_OE,
  // Internal state for observation
  output logic BUSY
);
  localparam int NG = 2 ** (ADDR_W - 2);
  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  sec_pkg::sec_pins_t pin_s1, pin_s2, pin_d;
  always_ff @(posedge MCLK) begin
    pin_s1 <= '{CS_N, SCK, SI, HOLD_N, WP_N};
    pin_s2 <= pin_s1;
    pin_d <= pin_s2;
  end
  wire logic sel = !pin_s2.cs_n;
  wire logic active = sel && pin_s2.pause_n;
  wire logic sck_rise = active && pin_s2.sck && !pin_d.sck;
  wire logic sck_fall = active && !pin_s2.sck && pin_d.sck;
  wire logic cs_rise = pin_s2.cs_n && !pin_d.cs_n;
  // ---------------------------------------------------------------
  // ECC: Hamming code over 32 data bits, 6 check bits
  // ---------------------------------------------------------------
  function automatic logic [5:0] ecc_gen(input logic [31:0] d);
    logic [5:0] c;
    logic [5:0] pos;
    c = 6'h00;
    pos = 6'h00;
    for (int i = 0, p = 3; i < 32; i++) begin
      while ((p & (p - 1)) == 0) p++;
      pos = 6'(p);
      if (d[i]) c = c ^ pos;
      p++;
    end
    return c;
  endfunction : ecc_gen
  function automatic logic [31:0] ecc_fix(input logic [31:0] d,
                                          input logic [5:0] c);
    logic [5:0] syn;
    logic [31:0] r;
    syn = ecc_gen(d) ^ c;
    r = d;
    for (int i = 0, p = 3; i < 32; i++) begin
      while ((p & (p - 1)) == 0) p++;
      if (syn == 6'(p)) r[i] = !r[i];
      p++;
    end
    return r;
  endfunction : ecc_fix
  // Protect decode, used by the write gate wr_ok
  function automatic logic in_protect(input logic [1:0] bp,
                                      input logic [15:0] a);
    unique case (bp)
      2'b00: return 1'b0;
      2'b01: return a[15:14] == 2'b11;
      2'b10: return a[15];
      2'b11: return 1'b1;
    endcase
  endfunction : in_protect
  // ---------------------------------------------------------------
  // Storage and state
  // ---------------------------------------------------------------
  logic [31:0] mem_data [NG];
  logic [5:0] mem_chk [NG];
  logic [2:0] nv; // lock, bp_hi, bp_lo
  logic write_enable_latch;
  logic busy;
  logic [$clog2(WRITE_TIME+1)-1:0] wcnt;
  logic pend_sr; // pending status write
  logic pend_mem;
  logic [2:0] sr_new;
  logic [ADDR_W-3:0] pg;
  logic [31:0] pg_data;
  logic [3:0] pg_mask;
  sec_pkg::sec_phase_t ph;
  logic [4:0] bitn;
  logic [7:0] shreg;
  logic [15:0] addr;
  logic [7:0] obyte;
  logic [2:0] obit;
  logic so_q, oe_q;
  wire logic [7:0] status = {nv[2], 3'b000, nv[1:0], write_enable_latch, busy};
  wire logic hw_lock = nv[2] && !pin_s2.guard_n;
  wire logic [7:0] sh_next = {shreg[6:0], pin_s2.si};
  wire logic [4:0] bit_next = bitn + 5'h01;
  wire logic [ADDR_W-3:0] ga = addr[ADDR_W-1:2];
  wire logic [31:0] rd_word = ecc_fix(mem_data[ga], mem_chk[ga]);
  wire logic [7:0] rd_byte = rd_word[8*addr[1:0] +: 8];
  wire logic opc_ok = (sh_next == sec_pkg::OP_CMD_WRITE_ENABLE) ||
    (sh_next == sec_pkg::OP_CMD_WRITE_DISABLE) || (sh_next == sec_pkg::OP_CMD_STATUS_READ) ||
    (sh_next == sec_pkg::OP_CMD_STATUS_WRITE) || (sh_next == sec_pkg::OP_READ) ||
    (sh_next == sec_pkg::OP_WRITE);
  logic [7:0] op;
  wire logic [31:0] merged = {
    pg_mask[3] ? pg_data[31:24] : mem_data[pg][31:24],
    pg_mask[2] ? pg_data[23:16] : mem_data[pg][23:16],
    pg_mask[1] ? pg_data[15:8] : mem_data[pg][15:8],
    pg_mask[0] ? pg_data[7:0] : mem_data[pg][7:0]};
  // ---------------------------------------------------------------
  // Frame decoder
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      ph <= sec_pkg::PH_IDLE;
      bitn <= 5'h00;
      shreg <= 8'h00;
      op <= 8'h00;
      addr <= 16'h0000;
      obyte <= 8'h00;
      obit <= 3'h0;
      so_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (!sel) begin
      ph <= sec_pkg::PH_OPC;
      bitn <= 5'h00;
      oe_q <= 1'b0;
    end else begin
      oe_q <= pin_s2.pause_n && (ph == sec_pkg::PH_RDAT ||
                                 ph == sec_pkg::PH_STAT);
      if (sck_rise) begin
        shreg <= sh_next;
        bitn <= bit_next;
        unique case (ph)
          sec_pkg::PH_OPC: if (bit_next == sec_pkg::CNT_OPC) begin
            op <= sh_next;
            if (!opc_ok) ph <= sec_pkg::PH_IDLE;
            else if (sh_next == sec_pkg::OP_CMD_STATUS_READ) begin
              ph <= sec_pkg::PH_STAT;
              obyte <= status;
              obit <= 3'h7;
            end else if (sh_next == sec_pkg::OP_CMD_STATUS_WRITE)
              ph <= sec_pkg::PH_SRIN;
            else if (sh_next == sec_pkg::OP_READ ||
                     sh_next == sec_pkg::OP_WRITE)
              ph <= busy ? sec_pkg::PH_IDLE : sec_pkg::PH_ADDR;
          end else if (bit_next > sec_pkg::CNT_OPC)
            ph <= sec_pkg::PH_IDLE;
          sec_pkg::PH_ADDR: begin
            addr <= {addr[14:0], pin_s2.si};
            if (bit_next == sec_pkg::CNT_ADDR) begin
              // Write data bits count per byte, so long pages never wrap it
              bitn <= 5'h00;
              if (op == sec_pkg::OP_READ) begin
                ph <= sec_pkg::PH_RDAT;
                obit <= 3'h7;
              end else ph <= sec_pkg::PH_WDAT;
            end
          end
          sec_pkg::PH_SRIN: if (bit_next > sec_pkg::CNT_SREG)
            ph <= sec_pkg::PH_IDLE;
          sec_pkg::PH_WDAT: if (bit_next == sec_pkg::CNT_OPC) begin
            bitn <= 5'h00;
            addr[6:0] <= addr[6:0] + 7'h01;
          end
          default: ;
        endcase
      end
      if (sck_fall) begin
        if (ph == sec_pkg::PH_RDAT) begin
          so_q <= (obit == 3'h7) ? rd_byte[7] : obyte[obit];
          if (obit == 3'h7) obyte <= rd_byte;
          if (obit == 3'h0) addr <= addr + 16'h0001;
          obit <= obit - 3'h1;
        end else if (ph == sec_pkg::PH_STAT) begin
          so_q <= (obit == 3'h7) ? status[7] : obyte[obit];
          if (obit == 3'h7) obyte <= status;
          obit <= obit - 3'h1;
        end
      end
    end
  end
  // ---------------------------------------------------------------
  // Write side: latch, status, page buffer, internal write timer
  // ---------------------------------------------------------------
  wire logic end_ok_op = ph == sec_pkg::PH_OPC && bitn == sec_pkg::CNT_OPC;
  wire logic wdat_byte = ph == sec_pkg::PH_WDAT && sck_rise &&
    bit_next[2:0] == 3'h0;
  wire logic wr_ok = write_enable_latch && !busy && !in_protect(nv[1:0], addr);
  // Bytes of an earlier group in the same page are dropped
  wire logic [3:0] mask_keep = (ga == pg) ? pg_mask : 4'h0;
  wire logic take_cmd_write_enable = cs_rise && !busy && end_ok_op &&
    op == sec_pkg::OP_CMD_WRITE_ENABLE;
  wire logic take_cmd_write_disable = cs_rise && !busy && end_ok_op &&
    op == sec_pkg::OP_CMD_WRITE_DISABLE;
  wire logic [5:0] erased_chk = ecc_gen({4{sec_pkg::MEM_ERASED}});
  wire logic sr_ok = ph == sec_pkg::PH_SRIN && bitn == sec_pkg::CNT_SREG &&
    write_enable_latch && !hw_lock;
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      nv <= sec_pkg::NV_RESET;
      write_enable_latch <= 1'b0;
      busy <= 1'b0;
      wcnt <= '0;
      pend_mem <= 1'b0;
      pend_sr <= 1'b0;
      sr_new <= 3'h0;
      pg <= '0;
      pg_data <= 32'h0000_0000;
      pg_mask <= 4'h0;
      // No retention in this model: reset leaves every group erased
      for (int g = 0; g < NG; g++) begin
        mem_data[g] <= {4{sec_pkg::MEM_ERASED}};
        mem_chk[g] <= erased_chk;
      end
    end else begin
      if (busy) begin
        if (wcnt == '0) begin
          busy <= 1'b0;
          write_enable_latch <= 1'b0;
          if (pend_sr) nv <= sr_new;
          if (pend_mem) begin
            mem_data[pg] <= merged;
            mem_chk[pg] <= ecc_gen(merged);
          end
          pend_sr <= 1'b0;
          pend_mem <= 1'b0;
          pg_mask <= 4'h0;
        end else wcnt <= wcnt - 1'b1;
      end
      if (wdat_byte && write_enable_latch && !busy) begin
        pg <= ga;
        pg_data[8*addr[1:0] +: 8] <= sh_next;
        pg_mask <= mask_keep | (4'(wr_ok) << addr[1:0]);
        pend_mem <= pend_mem | wr_ok;
      end
      if (ph == sec_pkg::PH_SRIN && sck_rise && bit_next == sec_pkg::CNT_SREG)
        sr_new <= {sh_next[7], sh_next[3:2]};
      if (cs_rise && !busy) begin
        if (take_cmd_write_enable) write_enable_latch <= 1'b1;
        if (take_cmd_write_disable) write_enable_latch <= 1'b0;
        if (sr_ok) begin
          pend_sr <= 1'b1;
          busy <= 1'b1;
          wcnt <= ($bits(wcnt))'(WRITE_TIME - 1);
        end
        if (ph == sec_pkg::PH_WDAT && bitn == 5'h00 && pend_mem &&
            write_enable_latch) begin
          busy <= 1'b1;
          wcnt <= ($bits(wcnt))'(WRITE_TIME - 1);
        end else if (!sr_ok) begin
          pend_mem <= 1'b0;
          pg_mask <= 4'h0;
        end
      end
    end
  end
  assign SO = so_q;
  assign SO_OE = oe_q;
  assign BUSY = busy;
  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_float_desel: assert property (@(posedge MCLK)
    disable iff (RESET) !sel |=> !SO_OE)
    else $error("output driven while deselected");
  chk_pause_float: assert property (@(posedge MCLK)
    disable iff (RESET) (sel && !pin_s2.pause_n) |=> !SO_OE)
    else $error("output driven during pause");
  chk_so_on_fall: assert property (@(posedge MCLK)
    disable iff (RESET) (sel && !sck_fall) |=> $stable(SO))
    else $error("output changed off falling edge");
  chk_wel_set: assert property (@(posedge MCLK)
    disable iff (RESET) $rose(write_enable_latch) |-> $past(take_cmd_write_enable))
    else $error("latch set without enable");
  chk_wel_enable: assert property (@(posedge MCLK)
    disable iff (RESET) take_cmd_write_enable |=> write_enable_latch)
    else $error("enable not taken");
  chk_wel_disable: assert property (@(posedge MCLK)
    disable iff (RESET) take_cmd_write_disable |=> !write_enable_latch)
    else $error("disable not taken");
  chk_busy_wel: assert property (@(posedge MCLK)
    disable iff (RESET) $fell(busy) |-> !write_enable_latch)
    else $error("latch kept after write");
  chk_lock_refuse: assert property (@(posedge MCLK)
    disable iff (RESET) (cs_rise && hw_lock && !busy) |=> !pend_sr)
    else $error("status write under lock");
  chk_stat_zero: assert property (@(posedge MCLK)
    disable iff (RESET) (ph == sec_pkg::PH_STAT && sck_fall &&
    obit >= 3'h4 && obit <= 3'h6) |=> !SO)
    else $error("reserved status bit sent as one");
  chk_ecc_single: assert property (@(posedge MCLK)
    disable iff (RESET) (ph == sec_pkg::PH_RDAT) |->
    ecc_fix(rd_word ^ (32'h0000_0001 << addr[4:0]), mem_chk[ga]) ==
    rd_word) else $error("single bit error not corrected");
endmodule : sec_eeprom
`default_nettype wire

//--- pkg/sec_pkg.sv
`default_nettype none
package sec_pkg;
  // ---------------------------------------------------------------
  // Opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_CMD_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_CMD_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_CMD_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_CMD_WRITE_ENABLE = 8'h06;
  // ---------------------------------------------------------------
  // Status field positions and reset values
  // ---------------------------------------------------------------
  localparam int ST_LOCK = 7;
  localparam int ST_BP_HI = 3;
  localparam int ST_BP_LO = 2;
  localparam int ST_WEL = 1;
  localparam int ST_BUSY = 0;
  localparam logic [2:0] NV_RESET = 3'h0;
  localparam logic [7:0] MEM_ERASED = 8'hff;
  // ---------------------------------------------------------------
  // Bit counts within a frame
  // ---------------------------------------------------------------
  localparam logic [4:0] CNT_OPC = 5'h08;
  localparam logic [4:0] CNT_ADDR = 5'h18;
  localparam logic [4:0] CNT_SREG = 5'h10;
  // ---------------------------------------------------------------
  // Internal write time
  // ---------------------------------------------------------------
  localparam real T_WRITE_MS = 5.0;
  localparam real CLK_MHZ = 40.0;
  localparam int WRITE_CYCLES = int'(T_WRITE_MS * 1000.0 * CLK_MHZ);
  typedef enum logic [2:0] {
    PH_OPC = 3'b000,
    PH_ADDR = 3'b001,
    PH_SRIN = 3'b010,
    PH_RDAT = 3'b011,
    PH_WDAT = 3'b100,
    PH_STAT = 3'b101,
    PH_IDLE = 3'b110
  } sec_phase_t;
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic pause_n;
    logic guard_n;
  } sec_pins_t;
endpackage : sec_pkg
`default_nettype wire

//--- verif/sec_host.sv
`default_nettype none
module sec_host (
  // Clock
  input wire logic MCLK,
  // Serial link
  input wire logic SO,
  input wire logic SO_OE,
  output logic CS_N,
  output logic SCK,
  output logic SI
);
  timeunit 1ns;
  timeprecision 1ps;
  // Four bench clocks a half period give the 200 ns link clock
  localparam int HALF = 4;
  initial begin
    CS_N = 1'b1;
    SCK = 1'b0;
    SI = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge MCLK);
  endtask : tick
  task automatic sel();
    CS_N <= 1'b0;
    tick(HALF);
  endtask : sel
  // Data line flips on release so a stale bit never looks driven
  task automatic desel();
    tick(HALF);
    CS_N <= 1'b1;
    SI <= ~SI;
    tick(3 * HALF);
  endtask : desel
  task automatic pulse(input logic b);
    SI <= b;
    tick(HALF);
    SCK <= 1'b1;
    tick(HALF);
    SCK <= 1'b0;
  endtask : pulse
  // Output taken mid-high, well clear of the falling-edge update
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      SI <= tx[i];
      tick(HALF);
      SCK <= 1'b1;
      tick(2);
      // A floating output reads as its inverse, so it never passes
      rx[i] = SO_OE ? SO : ~SO;
      tick(HALF - 2);
      SCK <= 1'b0;
    end
  endtask : xbyte
endmodule : sec_host
`default_nettype wire

//--- verif/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Short write time keeps the run small yet outlasts one status read
  localparam int WT = 400;
  logic MCLK = 1'b0;
  logic RESET = 1'b1;
  logic HOLD_N = 1'b1;
  logic WP_N = 1'b1;
  wire logic CS_N, SCK, SI, SO, SO_OE, BUSY;
  int n_mismatch = 0;
  int comparisons = 0;
  logic [15:0] lfsr = 16'h001d;
  logic [7:0] mem [logic [15:0]];
  logic [7:0] rx;
  logic [15:0] a;
  logic [1:0] bp;
  always #12.5 MCLK = ~MCLK;
  sec_eeprom #(.WRITE_TIME(WT)) dut_u (.MCLK(MCLK), .RESET(RESET),
    .CS_N(CS_N), .SCK(SCK), .SI(SI), .HOLD_N(HOLD_N), .WP_N(WP_N),
    .SO(SO), .SO_OE(SO_OE), .BUSY(BUSY));
  sec_host host_u (.MCLK(MCLK), .SO(SO), .SO_OE(SO_OE), .CS_N(CS_N),
    .SCK(SCK), .SI(SI));
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[7:0];
  endfunction : rnd
  function automatic logic [7:0] ex(input logic [15:0] x);
    return mem.exists(x) ? mem[x] : sec_pkg::MEM_ERASED;
  endfunction : ex
  function automatic logic prot(input logic [1:0] b, input logic [15:0] x);
    return (b == 2'b11) || (b == 2'b10 && x[15]) ||
      (b == 2'b01 && x[15:14] == 2'b11);
  endfunction : prot
  task automatic end_sim();
    $display("counts: %0d compares, %0d mismatches", comparisons,
      n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic idle();
    for (int i = 0; i < 1000 && BUSY !== 1'b0; i++) @(posedge MCLK);
    if (BUSY !== 1'b0) begin
      n_mismatch++;
      end_sim();
    end
  endtask : idle
  task automatic cmd(input logic [7:0] op);
    host_u.sel();
    host_u.xbyte(op, rx);
    host_u.desel();
  endtask : cmd
  task automatic ws(input logic [7:0] v);
    host_u.sel();
    host_u.xbyte(sec_pkg::OP_CMD_STATUS_WRITE, rx);
    host_u.xbyte(v, rx);
    host_u.desel();
  endtask : ws
  task automatic hdr(input logic [7:0] op, input logic [15:0] x);
    host_u.sel();
    host_u.xbyte(op, rx);
    host_u.xbyte(x[15:8], rx);
    host_u.xbyte(x[7:0], rx);
  endtask : hdr
  task automatic wr(input logic [15:0] x, input logic [7:0] d,
      input logic ok);
    hdr(sec_pkg::OP_WRITE, x);
    host_u.xbyte(d, rx);
    host_u.desel();
    if (ok) mem[x] = d;
  endtask : wr
  task automatic wr4(input logic [15:0] x);
    logic [7:0] d;
    hdr(sec_pkg::OP_WRITE, x);
    for (int i = 0; i < 4; i++) begin
      d = rnd();
      host_u.xbyte(d, rx);
      mem[x + 16'(i)] = d;
    end
    host_u.desel();
  endtask : wr4
  // Select stays low throughout the pause
  // Clock rests low around both pause edges
  task automatic pause();
    host_u.tick(4);
    HOLD_N <= 1'b0;
    host_u.tick(4);
    repeat (3) host_u.pulse(1'b1);
    host_u.tick(4);
    check({7'h00, SO_OE}, 8'h00);
    HOLD_N <= 1'b1;
    host_u.tick(4);
  endtask : pause
  task automatic rd(input logic [15:0] x, input int n, input logic hold);
    logic [15:0] ai;
    hdr(sec_pkg::OP_READ, x);
    for (int i = 0; i < n; i++) begin
      ai = x + 16'(i);
      if (hold && i == 1) pause();
      host_u.xbyte(rnd(), rx);
      check(rx, ex(ai));
      check({7'h00, SO_OE}, 8'h01);
    end
    host_u.desel();
  endtask : rd
  task automatic st(input logic [7:0] e);
    logic [7:0] s;
    host_u.sel();
    host_u.xbyte(sec_pkg::OP_CMD_STATUS_READ, rx);
    host_u.xbyte(rnd(), s);
    check(s, e);
    host_u.xbyte(rnd(), s);
    check(s, e);
    host_u.desel();
    check({7'h00, SO_OE}, 8'h00);
  endtask : st
  initial begin
    repeat (5) @(posedge MCLK);
    RESET <= 1'b0;
    host_u.tick(4);
    st(8'h00);
    a = {rnd(), rnd()};
    wr(a, rnd(), 1'b0);
    rd(a, 1, 1'b0);
    host_u.sel();
    host_u.xbyte(sec_pkg::OP_CMD_WRITE_ENABLE, rx);
    host_u.pulse(1'b0);
    host_u.desel();
    st(8'h00);
    host_u.sel();
    host_u.xbyte(8'haa, rx);
    host_u.xbyte(sec_pkg::OP_CMD_WRITE_ENABLE, rx);
    host_u.desel();
    st(8'h00);
    cmd(sec_pkg::OP_CMD_WRITE_ENABLE);
    st(8'h02);
    cmd(sec_pkg::OP_CMD_WRITE_DISABLE);
    st(8'h00);
    $display("test latch done");
    // First pass writes address zero so the read wraps from the top
    for (int k = 0; k < 8; k++) begin
      a = {rnd(), rnd()};
      if (k == 0) a = 16'h0000;
      cmd(sec_pkg::OP_CMD_WRITE_ENABLE);
      wr(a, rnd(), 1'b1);
      check({7'h00, BUSY}, 8'h01);
      st(8'h03);
      idle();
      st(8'h00);
      rd(a - 16'h0001, 3, k[0]);
    end
    a = {rnd(), rnd() & 8'hfc};
    cmd(sec_pkg::OP_CMD_WRITE_ENABLE);
    wr4(a);
    idle();
    rd(a, 4, 1'b0);
    $display("test data done");
    for (int b = 0; b < 4; b++) begin
      bp = 2'(b);
      cmd(sec_pkg::OP_CMD_WRITE_ENABLE);
      ws({4'h7, bp, 2'b11});
      idle();
      st({4'h0, bp, 2'b00});
      for (int j = 0; j < 4; j++) begin
        a = {2'(j), b[0] ? 14'h3fff : 14'h0000};
        cmd(sec_pkg::OP_CMD_WRITE_ENABLE);
        wr(a, rnd(), !prot(bp, a));
        idle();
        rd(a, 1, 1'b0);
      end
    end
    $display("test protect done");
    cmd(sec_pkg::OP_CMD_WRITE_ENABLE);
    ws(8'h80);
    idle();
    st(8'h80);
    WP_N <= 1'b0;
    cmd(sec_pkg::OP_CMD_WRITE_ENABLE);
    ws(8'h0c);
    idle();
    st(8'h82);
    WP_N <= 1'b1;
    ws(8'h00);
    idle();
    st(8'h00);
    $display("test lock done");
    end_sim();
  end
endmodule : tb
`default_nettype wire
